// File: rtl/adc_serial_host_sequencer.sv
// host-side sequencer driving the converter over select, clock and data pins
`timescale 1ns/100ps
module adc_serial_host_sequencer #(
  parameter int DELAY_CYC = adc_host_pkg::POST_DELAY_CYC,
  parameter int HALF_CYC = adc_host_pkg::SCK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic hostStart,
  input wire logic endOfConvPin,
  input wire logic parallelMsbLine,
  input wire logic serialResultOut,
  input wire logic otherBusReq,
  output logic serialClk,
  output logic hostSelectLine0,
  output logic hostSelectLine1,
  output logic [15:0] result,
  output logic resultValid,
  output logic [7:0] cmdByte,
  output logic busy
);
  typedef struct packed {
    adc_host_pkg::state_t st;
    logic phase;
    logic [4:0] bitCnt;
    logic [15:0] divCnt;
    logic [31:0] gapCnt;
    logic [15:0] shift;
    logic [15:0] res;
    logic valid;
    logic sck;
    logic sel0;
    logic sel1;
    logic eocPrev;
    logic [7:0] cmd;
  } st_t;
  st_t s_r;
  st_t s_nxt;
  logic eocSync;
  logic msbSync;
  logic serSync;
  logic dataIn;

  // end-of-conversion idles high
  sync2 #(.RST_VAL(1'b1)) u_eoc (.clk(clk), .rst_n(rst_n), .d(endOfConvPin), .q(eocSync));
  sync2 u_msb (.clk(clk), .rst_n(rst_n), .d(parallelMsbLine), .q(msbSync));
  sync2 u_ser (.clk(clk), .rst_n(rst_n), .d(serialResultOut), .q(serSync));

  // hostStart high: host issues conversions, data on shared msb line
  assign dataIn = hostStart ? msbSync : serSync; // [R3]

  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.eocPrev = eocSync;
    case (s_r.st)
      adc_host_pkg::IDLE: begin
        s_nxt.sck = 1'b0; // [R10]
        s_nxt.sel0 = 1'b1; // [R4]
        s_nxt.sel1 = 1'b1; // [R4]
        // other peripherals hold the bus: selects stay high
        if (enable && !otherBusReq) begin
          if (hostStart) begin
            s_nxt.st = adc_host_pkg::XFER;
            s_nxt.phase = 1'b0;
            // shortest convert pulse the queue can make [R16]
            s_nxt.bitCnt = 5'(adc_host_pkg::START_BITS); // [R5]
            s_nxt.cmd = adc_host_pkg::CMD_START; // [R11]
            s_nxt.sel0 = 1'b0; // [R5]
            s_nxt.sel1 = 1'b0; // [R5]
            s_nxt.divCnt = '0; // no pre-clock delay [R8]
          end else begin
            s_nxt.st = adc_host_pkg::ARM;
          end
        end
      end
      adc_host_pkg::ARM: begin
        // port opens only on a fresh rising edge, keeps word alignment
        if (!s_r.eocPrev && eocSync) begin // [R1] [R2] [R14]
          s_nxt.st = adc_host_pkg::XFER;
          s_nxt.phase = 1'b1;
          s_nxt.bitCnt = 5'(adc_host_pkg::RESULT_BITS);
          s_nxt.cmd = adc_host_pkg::CMD_RESULT; // [R11]
          s_nxt.sel1 = 1'b0;
          s_nxt.divCnt = '0;
        end else if (!enable) begin
          s_nxt.st = adc_host_pkg::IDLE;
        end
      end
      adc_host_pkg::XFER: begin
        if (s_r.divCnt == 16'(HALF_CYC - 1)) begin // [R9]
          s_nxt.divCnt = '0;
          s_nxt.sck = ~s_r.sck;
          if (!s_r.sck) begin
            // rising edge: sample
            if (s_r.phase) begin
              s_nxt.shift = {s_r.shift[14:0], dataIn}; // [R6] [R10]
            end
          end else begin
            s_nxt.bitCnt = s_r.bitCnt - 5'h1;
            if (s_r.bitCnt == 5'h1) begin
              s_nxt.st = adc_host_pkg::GAP;
              s_nxt.gapCnt = '0;
              s_nxt.sel0 = 1'b1;
              s_nxt.sel1 = 1'b1;
              if (s_r.phase) begin
                s_nxt.res = s_r.shift; // [R12]
                s_nxt.valid = 1'b1;
              end
            end
          end
        end else begin
          s_nxt.divCnt = s_r.divCnt + 16'h1;
        end
      end
      adc_host_pkg::GAP: begin
        if (s_r.gapCnt >= 32'(DELAY_CYC - 1)) begin // [R7]
          if (!enable) begin
            s_nxt.st = adc_host_pkg::IDLE;
          end else if (!hostStart) begin
            s_nxt.st = adc_host_pkg::ARM;
          end else if (!s_r.phase) begin // start frame every second frame [R15]
            // start transfer done: result transfer next
            s_nxt.st = adc_host_pkg::XFER;
            s_nxt.phase = 1'b1;
            s_nxt.bitCnt = 5'(adc_host_pkg::RESULT_BITS); // [R6]
            s_nxt.cmd = adc_host_pkg::CMD_RESULT; // [R11]
            s_nxt.sel1 = 1'b0; // [R6]
            s_nxt.divCnt = '0;
          end else begin
            // queue wraps only after the result is in
            s_nxt.st = adc_host_pkg::IDLE; // [R7] [R18]
          end
        end else begin
          // counter-timed, so no start jitter; the gap caps the rate [R13] [R17]
          s_nxt.gapCnt = s_r.gapCnt + 32'h1;
        end
      end
      default: begin
        s_nxt.st = adc_host_pkg::IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.st <= adc_host_pkg::IDLE;
      s_r.phase <= 1'b0;
      s_r.bitCnt <= 5'h0;
      s_r.divCnt <= 16'h0;
      s_r.gapCnt <= 32'h0;
      s_r.shift <= 16'h0;
      s_r.res <= adc_host_pkg::RESULT_RESET;
      s_r.valid <= 1'b0;
      s_r.sck <= 1'b0;
      s_r.sel0 <= 1'b1;
      s_r.sel1 <= 1'b1;
      s_r.eocPrev <= 1'b1;
      s_r.cmd <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign serialClk = s_r.sck;
  assign hostSelectLine0 = s_r.sel0;
  assign hostSelectLine1 = s_r.sel1;
  assign result = s_r.res;
  assign resultValid = s_r.valid;
  assign cmdByte = s_r.cmd;
  assign busy = (s_r.st != adc_host_pkg::IDLE);
endmodule : adc_serial_host_sequencer

// File: rtl/adc_host_pkg.sv
// constants for the converter host sequencer
// Notes on behaviour
// R1: in wait mode, enable serial port only after end-of-conversion rises.
// R2: converter raises end-of-conversion when a conversion completes.
// R3: shared bus: data comes from the tri-stating parallel msb line.
// R4: both select lines stay high while other peripherals are addressed; the code checks otherBusReq only when leaving IDLE.
// R5: an 8-bit transfer with both selects low starts a conversion.
// R6: a 16-bit transfer with only chip select low reads the result.
// R7: after each transfer wait about 19 us, then wrap the queue.
// R8: fastest setting: clock divider 2, delay 10, no pre-clock delay.
// R9: slower rates lengthen the delay, never the serial clock.
// R10: serial clock idles low, data sampled on the rising edge.
// R11: command byte 20 hex for start, 61 hex for result transfer.
// R12: an 8-bit host saves the upper byte before the lower arrives.
// R13: software-made start pulses give jitter, near-dc use only.
// R14: dsp host also waits for end-of-conversion rising before enabling.
// R15: dsp one-shot mode: async, frame sync every second frame, prescale 3.
// R16: one-shot pulse width near the converter minimum convert width.
// R17: dsp at 20.48 MHz reaches 40 kHz at most.
// R18: no new start transfer before the result transfer has finished.
// R19: convert during analog power-down yields meaningless data.
package adc_host_pkg;
  localparam int CLK_MHZ = 100;
  localparam int SCK_HALF_CYC = 12;
  localparam int POST_DELAY_NS = 19000;
  localparam int POST_DELAY_CYC = (POST_DELAY_NS * CLK_MHZ) / 1000;
  localparam int START_BITS = 8;
  localparam int RESULT_BITS = 16;
  localparam logic [7:0] CMD_START = 8'h20;
  localparam logic [7:0] CMD_RESULT = 8'h61;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  typedef enum logic [2:0] {IDLE, ARM, XFER, GAP} state_t;
endpackage : adc_host_pkg

// File: rtl/sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic [1:0] s_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // reset to the pin's idle level, else a false edge follows reset
      s_r <= {2{RST_VAL}};
    end else begin
      s_r <= {s_r[0], d};
    end
  end
  assign q = s_r[1];
endmodule : sync2

// File: verification/adc_host_properties.sv
// pin assertions for the host sequencer
`timescale 1ns/100ps
module adc_host_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic otherBusReq,
  input wire logic serialClk,
  input wire logic hostSelectLine0,
  input wire logic hostSelectLine1,
  input wire logic [15:0] result,
  input wire logic resultValid,
  input wire logic [7:0] cmdByte,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  idle_sel_a: assert property (!busy |-> hostSelectLine0 && hostSelectLine1)
    else $error("idle select");
  idle_sck_a: assert property (!busy |-> !serialClk) else $error("idle sck");
  start_cmd_a: assert property (!hostSelectLine0 |-> !hostSelectLine1 && cmdByte == 8'h20)
    else $error("start cmd");
  read_cmd_a: assert property ($fell(hostSelectLine1) && hostSelectLine0 |-> cmdByte == 8'h61)
    else $error("read cmd");
  start_gap_a: assert property ($rose(hostSelectLine0) |-> hostSelectLine1 [*8])
    else $error("no gap");
  sel_edge_a: assert property ($changed(hostSelectLine1) |-> !serialClk) else $error("sel edge");
  valid_once_a: assert property (resultValid |=> !resultValid && $stable(result))
    else $error("valid");
  bus_hold_a: assert property (!busy && otherBusReq |=> !busy) else $error("bus hold");
  rate_limit_a: assert property ($rose(resultValid) |-> hostSelectLine0 [*8])
    else $error("rate limit");
  cover property (resultValid);
  cover property ($fell(hostSelectLine0));
  cover property (otherBusReq && !busy);
endmodule : adc_host_properties
bind adc_serial_host_sequencer adc_host_properties chk (.clk, .rst_n, .otherBusReq, .serialClk,
  .hostSelectLine0, .hostSelectLine1, .result, .resultValid, .cmdByte, .busy);

// File: verification/adc_device_model.sv
// behavioural converter at the far side
`timescale 1ns/100ps
module adc_device_model #(
  parameter int CONV_NS = 100
) (
  input wire logic serialClk,
  input wire logic hostSelectLine0,
  input wire logic hostSelectLine1,
  input wire logic [15:0] sample,
  output logic endOfConvPin,
  output logic parallelMsbLine,
  output logic serialResultOut
);
  logic [15:0] sh = 16'h0000;
  logic last = 1'b0;
  initial endOfConvPin = 1'b1;
  task automatic convert;
    endOfConvPin = 1'b0;
    #(CONV_NS) sh = sample; // analog power-down never raised here
    endOfConvPin = 1'b1;
  endtask : convert
  always @(negedge hostSelectLine0) begin
    #1 if (!hostSelectLine1) convert();
  end
  // read mode only, so the start transfer cannot eat result bits
  always @(negedge serialClk) if (hostSelectLine0 && !hostSelectLine1) sh = sh << 1;
  always @(posedge hostSelectLine1) last = sh[15];
  // no pull on the released line: show the inverse of its last bit
  assign parallelMsbLine = hostSelectLine1 ? ~last : sh[15];
  assign serialResultOut = sh[15];
endmodule : adc_device_model

// File: verification/adc_serial_host_sequencer_tb.sv
// self-checking bench for the host sequencer
`timescale 1ns/100ps
module adc_serial_host_sequencer_tb;
  logic clk = 1'b0, rst_n = 1'b0, enable = 1'b0, hostStart = 1'b0, otherBusReq = 1'b0;
  logic [15:0] sample = 16'h0000, result;
  logic [7:0] cmdByte;
  logic endOfConvPin, parallelMsbLine, serialResultOut, serialClk, sel0, sel1, resultValid, busy;
  int n_errors = 0, n_compared = 0, cycles = 0;
  initial forever #5 clk = ~clk;
  // half period must exceed the two-flop sync latency on the data pin
  adc_serial_host_sequencer #(.DELAY_CYC(20), .HALF_CYC(4)) uut (.clk, .rst_n, .enable,
    .hostStart, .endOfConvPin, .parallelMsbLine, .serialResultOut, .otherBusReq, .serialClk,
    .hostSelectLine0(sel0), .hostSelectLine1(sel1), .result, .resultValid, .cmdByte, .busy);
  adc_device_model dev (.serialClk, .hostSelectLine0(sel0), .hostSelectLine1(sel1), .sample,
    .endOfConvPin, .parallelMsbLine, .serialResultOut);
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task convert(input logic hs, input logic [15:0] smp);
    int i;
    @(negedge clk);
    hostStart = hs;
    sample = smp;
    enable = 1'b1;
    if (!hs) dev.convert();
    for (i = 0; i < 400 && resultValid !== 1'b1; i++) @(negedge clk);
    enable = 1'b0;
    check("valid", {15'h0000, resultValid}, 16'h0001);
    check("result", result, smp);
    check("cmd", {8'h00, cmdByte}, 16'h0061);
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk);
  endtask : convert
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    convert(1'b1, 16'h8001);
    convert(1'b1, 16'h7ffe);
    convert(1'b0, 16'hc3a5);
    otherBusReq = 1'b1;
    enable = 1'b1;
    repeat (40) @(negedge clk);
    check("bus", {13'h0000, busy, sel0, sel1}, 16'h0003);
    stop_test();
  end
  // hang guard
  always @(posedge clk) if (++cycles > 20000) begin
    n_errors++;
    stop_test();
  end
endmodule : adc_serial_host_sequencer_tb
